// File: hw/dpr_dram_dev.sv
// Purpose: DRAM end with mode registers, pattern readout and DLL-off timing
// Assumes: commands registered on rising clk; one beat per cycle
// Notes: one read in flight; a read arriving while busy is dropped
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// - Both lanes replicate pattern bit on all bits
// - Pattern reads ignore bank and upper column bits
// - Controller drives A1 A0 zero
// - BL8 needs A2 low, order zero to seven
// - Chopped burst nibble chosen by A2
// - Chop on the fly via A12 when enabled
// - Pattern reads use ordinary read latency
// - Controller reads pattern only with DLL locked
// - Beat zero LSB, beat seven MSB
// - Calibration location alternates zero one; others reserved
// - NOP registers nothing, work continues
// - Deselect executes nothing, work continues
// - MR1 A0 set turns DLL off
// - DLL off uses CL six, CWL six
// - DLL off strobes one cycle earlier
// - Controller limits clock rate in DLL off; this controller has no clock rate control
// - DLL off entry via idle, tMOD, self-refresh
// - CKE high, ODT low after self-refresh exit
// - Wait tXS, then tMOD after mode writes
// - MR3 A2 enables pattern; read only
// - No other commands while pattern enabled
module dpr_dram_dev (
  input wire logic clk,
  input wire logic reset,
  dpr_link_if.dev link,
  input wire logic [dpr_pkg::DQ_W-1:0] array_data,
  output logic dll_off,
  output logic pattern_en,
  output logic in_self_refresh,
  output logic read_busy
);
  import dpr_pkg::*;

  typedef enum {st_idle, st_wait, st_burst} dpr_rd_state_e;

  logic sel, is_mrs, is_rd, is_ref;
  logic [ADDR_W-1:0] mr_q [MR_NUM];
  logic [ADDR_W-1:0] mr_d [MR_NUM];
  logic [ADDR_W-1:0] mr0, mr1, mr3;
  logic [4:0] cl_v, al_v, rl_v;
  logic [1:0] bl_code;
  logic bc4;
  logic sr_q, sr_d;
  dpr_rd_state_e st_q, st_d;
  logic [4:0] lat_q, lat_d;
  logic [2:0] beat_q, beat_d;
  logic [3:0] left_q, left_d;
  logic pat_q, pat_d;
  logic [1:0] loc_q, loc_d;
  logic [DQ_W-1:0] dq_q, dq_d;
  logic dq_oe_q, dq_oe_d, dqs_q, dqs_d;
  logic emit, pat_bit;
  logic [DQ_W-1:0] beat_word;

  // Command decode; anything else is a NOP or deselect
  always_comb begin
    sel = ~link.cs_n & ~sr_q;
    is_mrs = sel & ~link.ras_n & ~link.cas_n & ~link.we_n;
    is_rd = sel & link.ras_n & ~link.cas_n & link.we_n;
    is_ref = sel & ~link.ras_n & ~link.cas_n & link.we_n;
  end

  // Mode registers, written only with no read in flight
  always_comb begin
    mr_d = mr_q;
    if (is_mrs && st_q == st_idle) begin
      mr_d[link.ba[MR_IDX_W-1:0]] = link.addr;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      mr_q <= '{default: MR_RST};
    end else begin
      mr_q <= mr_d;
    end
  end

  assign mr0 = mr_q[BA_MR0[MR_IDX_W-1:0]];
  assign mr1 = mr_q[BA_MR1[MR_IDX_W-1:0]];
  assign mr3 = mr_q[BA_MR3[MR_IDX_W-1:0]];
  assign dll_off = mr1[MR1_DLL_OFF_BIT];
  assign pattern_en = mr3[MR3_EN_BIT];

  // Read latency; the DLL-off pair CL6/CWL6 comes in through MR0/MR2
  always_comb begin
    cl_v = CL_BASE + 5'(mr0[MR0_CL_LSB +: 3]);
    case (mr1[MR1_AL_LSB +: 2])
      AL_CL1: al_v = cl_v - 5'h01;
      AL_CL2: al_v = cl_v - 5'h02;
      default: al_v = 5'h00;
    endcase
    rl_v = al_v + cl_v - (dll_off ? 5'h01 : 5'h00);
    bl_code = mr0[MR0_BL_LSB +: 2];
    case (bl_code)
      BL_FIXED4: bc4 = 1'b1;
      BL_OTF: bc4 = ~link.addr[A_BC_BIT];
      default: bc4 = 1'b0;
    endcase
  end

  // Self-refresh tracking: refresh with CKE low enters, CKE high exits
  always_comb begin
    sr_d = sr_q;
    if (!sr_q && is_ref && !link.cke && st_q == st_idle) begin
      sr_d = 1'b1;
    end else if (sr_q && link.cke) begin
      sr_d = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      sr_q <= 1'b0;
    end else begin
      sr_q <= sr_d;
    end
  end

  assign in_self_refresh = sr_q;

  // Beat data: pattern location bit per beat, beat 0 in the LSB
  assign pat_bit = (loc_q == LOC_CAL) & CAL_PATTERN[beat_q];

  for (genvar i = 0; i < DQ_W; i++) begin : g_lane
    assign beat_word[i] = pat_q ? pat_bit : array_data[i];
  end

  // Read engine: latency wait, then one beat per cycle
  always_comb begin
    st_d = st_q;
    lat_d = lat_q;
    beat_d = beat_q;
    left_d = left_q;
    pat_d = pat_q;
    loc_d = loc_q;
    dq_d = dq_q;
    dq_oe_d = 1'b0;
    dqs_d = 1'b0;
    emit = 1'b0;
    case (st_q)
      st_idle: begin
        if (is_rd) begin
          // Bank, A10/AP and upper column bits play no part here
          st_d = st_wait;
          lat_d = rl_v - RL_PIPE;
          left_d = bc4 ? BEATS_BC4 : BEATS_BL8;
          beat_d = (bc4 && link.addr[A_NIB_BIT]) ? NIB_HI_START
                                                 : NIB_LO_START;
          pat_d = pattern_en;
          loc_d = mr3[MR3_LOC_LSB +: 2];
        end
      end
      st_wait: begin
        if (lat_q == 5'h00) begin
          emit = 1'b1;
        end else begin
          lat_d = lat_q - 5'h01;
        end
      end
      st_burst: begin
        emit = 1'b1;
      end
      default: begin
        st_d = st_idle;
      end
    endcase
    if (emit) begin
      dq_d = beat_word;
      dq_oe_d = 1'b1;
      dqs_d = ~beat_q[0];
      beat_d = beat_q + 3'h1;
      left_d = left_q - 4'h1;
      st_d = (left_q == 4'h1) ? st_idle : st_burst;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_q <= st_idle;
      lat_q <= 5'h00;
      beat_q <= 3'h0;
      left_q <= 4'h0;
      pat_q <= 1'b0;
      loc_q <= 2'h0;
      dq_q <= '0;
      dq_oe_q <= 1'b0;
      dqs_q <= 1'b0;
    end else begin
      st_q <= st_d;
      lat_q <= lat_d;
      beat_q <= beat_d;
      left_q <= left_d;
      pat_q <= pat_d;
      loc_q <= loc_d;
      dq_q <= dq_d;
      dq_oe_q <= dq_oe_d;
      dqs_q <= dqs_d;
    end
  end

  assign link.dq_dev = dq_q;
  assign link.dq_dev_oe = dq_oe_q;
  assign link.dqs_dev = dqs_q;
  assign link.dqs_dev_oe = dq_oe_q;
  assign read_busy = (st_q != st_idle);
endmodule : dpr_dram_dev
`default_nettype wire

// File: hw/dpr_pkg.sv
// Purpose: shared constants and types for the pattern-read link pair
// Assumes: one beat per clk cycle on the data lanes
// Notes: mode register fields follow the address bit positions
package dpr_pkg;
  localparam int ADDR_W = 14;
  localparam int BA_W = 3;
  localparam int DQ_W = 16;
  localparam int MR_NUM = 4;
  localparam int MR_IDX_W = 2;
  localparam int BUF_DEPTH = 2;
  // Mode register selects on the bank address
  localparam logic [BA_W-1:0] BA_MR0 = 3'h0;
  localparam logic [BA_W-1:0] BA_MR1 = 3'h1;
  localparam logic [BA_W-1:0] BA_MR2 = 3'h2;
  localparam logic [BA_W-1:0] BA_MR3 = 3'h3;
  // Field positions
  localparam int MR0_BL_LSB = 0;
  localparam int MR0_CL_LSB = 4;
  localparam int MR1_DLL_OFF_BIT = 0;
  localparam int MR1_AL_LSB = 3;
  localparam int MR2_CWL_LSB = 3;
  localparam int MR3_LOC_LSB = 0;
  localparam int MR3_EN_BIT = 2;
  localparam int A_BC_BIT = 12;
  localparam int A_NIB_BIT = 2;
  localparam logic [ADDR_W-1:0] MR_RST = 14'h0000;
  // Burst length codes
  localparam logic [1:0] BL_FIXED8 = 2'h0;
  localparam logic [1:0] BL_OTF = 2'h1;
  localparam logic [1:0] BL_FIXED4 = 2'h2;
  localparam logic [3:0] BEATS_BL8 = 4'h8;
  localparam logic [3:0] BEATS_BC4 = 4'h4;
  localparam logic [2:0] NIB_LO_START = 3'h0;
  localparam logic [2:0] NIB_HI_START = 3'h4;
  // Latency encodings
  localparam logic [4:0] CL_BASE = 5'h04;
  localparam logic [2:0] CL6_CODE = 3'h2;
  localparam logic [2:0] CWL6_CODE = 3'h1;
  localparam logic [1:0] AL_CL1 = 2'h1;
  localparam logic [1:0] AL_CL2 = 2'h2;
  localparam logic [4:0] RL_PIPE = 5'h02;
  // Pattern location and content, beat 0 in the LSB
  localparam logic [1:0] LOC_CAL = 2'h0;
  localparam logic [7:0] CAL_PATTERN = 8'haa;
  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int T_MOD_NCK = 12;
  localparam int T_CKSRE_NCK = 5;
  localparam int T_XS_NS = 170;
  localparam int T_XS_CYC = (T_XS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int READ_GAP_NCK = 32;
  localparam int GAP_W = 6;

  typedef enum logic [2:0] {
    op_nop, op_mode, op_read, op_sr_enter, op_sr_exit
  } dpr_op_e;

  typedef struct packed {
    dpr_op_e op;
    logic [BA_W-1:0] ba;
    logic [ADDR_W-1:0] addr;
  } dpr_cmd_s;
endpackage : dpr_pkg

// File: hw/dpr_link_if.sv
// Purpose: command, address and data lanes between controller and DRAM
// Assumes: both ends run on clk; rising clk is the CK/CK# crossing
// Notes: lane level is dq_dev when dq_dev_oe, else dq_host when dq_host_oe
`timescale 1ns/1ns
`default_nettype none
interface dpr_link_if (
  input wire logic clk
);
  logic cke;
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic odt;
  logic [dpr_pkg::BA_W-1:0] ba;
  logic [dpr_pkg::ADDR_W-1:0] addr;
  logic [dpr_pkg::DQ_W-1:0] dq_dev;
  logic dq_dev_oe;
  logic [dpr_pkg::DQ_W-1:0] dq_host;
  logic dq_host_oe;
  logic dqs_dev;
  logic dqs_dev_oe;

  modport dev (
    input clk, cke, cs_n, ras_n, cas_n, we_n, odt, ba, addr,
    input dq_host, dq_host_oe,
    output dq_dev, dq_dev_oe, dqs_dev, dqs_dev_oe
  );
  modport host (
    input clk, dq_dev, dq_dev_oe, dqs_dev, dqs_dev_oe,
    output cke, cs_n, ras_n, cas_n, we_n, odt, ba, addr,
    output dq_host, dq_host_oe
  );
endinterface : dpr_link_if
`default_nettype wire

// File: hw/dpr_buf2.sv
// Purpose: two-entry buffer with valid and ready on both sides
// Assumes: single clock, synchronous reset
// Notes: output data comes straight from the storage flops
`timescale 1ns/1ns
`default_nettype none
module dpr_buf2 #(
  parameter int W = 20
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  import dpr_pkg::*;
  logic [W-1:0] mem_q [BUF_DEPTH];
  logic [W-1:0] mem_d [BUF_DEPTH];
  logic wp_q, wp_d, rp_q, rp_d;
  logic [1:0] cnt_q, cnt_d;
  logic push, pop;

  assign in_ready = (cnt_q != 2'(BUF_DEPTH));
  assign out_valid = (cnt_q != 2'h0);
  assign out_data = mem_q[rp_q];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_comb begin
    mem_d = mem_q;
    wp_d = wp_q;
    rp_d = rp_q;
    cnt_d = cnt_q;
    if (push) begin
      mem_d[wp_q] = in_data;
      wp_d = ~wp_q;
    end
    if (pop) begin
      rp_d = ~rp_q;
    end
    if (push && !pop) begin
      cnt_d = cnt_q + 2'h1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 2'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      mem_q <= '{default: '0};
      wp_q <= 1'b0;
      rp_q <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      mem_q <= mem_d;
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
    end
  end
endmodule : dpr_buf2
`default_nettype wire

// File: hw/dpr_ctrl_host.sv
// Purpose: controller end issuing mode, read and self-refresh commands
// Assumes: user commands queue in a two-entry buffer
// Notes: odt held low and host never drives the data lanes
`timescale 1ns/1ns
`default_nettype none
module dpr_ctrl_host (
  input wire logic clk,
  input wire logic reset,
  dpr_link_if.host link,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire dpr_pkg::dpr_cmd_s cmd,
  output logic cmd_refused,
  output logic rd_valid,
  output logic [dpr_pkg::DQ_W-1:0] rd_data
);
  import dpr_pkg::*;
  logic q_valid, take, ok, bl8, dll_next;
  logic [$bits(dpr_cmd_s)-1:0] q_word;
  dpr_cmd_s qc;
  logic [ADDR_W-1:0] a;
  logic [GAP_W-1:0] gap_q, gap_d;
  logic cke_q, cke_d, cs_n_q, cs_n_d, ras_n_q, ras_n_d;
  logic cas_n_q, cas_n_d, we_n_q, we_n_d;
  logic [BA_W-1:0] ba_q, ba_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic sr_q, sr_d, pat_q, pat_d, dll_off_q, dll_off_d;
  logic [1:0] bl_q, bl_d;
  logic ref_q, ref_d, rv_q, rv_d;
  logic [DQ_W-1:0] rd_q, rd_d;

  dpr_buf2 #(.W($bits(dpr_cmd_s))) u_cmd_buf (
    .clk(clk),
    .reset(reset),
    .in_valid(cmd_valid),
    .in_ready(cmd_ready),
    .in_data(cmd),
    .out_valid(q_valid),
    .out_ready(take),
    .out_data(q_word)
  );

  assign qc = dpr_cmd_s'(q_word);
  assign take = q_valid & (gap_q == '0);

  always_comb begin
    a = qc.addr;
    ok = 1'b1;
    if (pat_q && !(qc.op == op_read ||
        (qc.op == op_mode && qc.ba == BA_MR3))) begin
      ok = 1'b0;
    end
    if (qc.op == op_read && pat_q && dll_off_q) begin
      ok = 1'b0;
    end
    if (sr_q ? (qc.op != op_sr_exit) : (qc.op == op_sr_exit)) begin
      ok = 1'b0;
    end
    dll_next = (qc.ba == BA_MR1) ? a[MR1_DLL_OFF_BIT] : dll_off_q;
    bl8 = (bl_q == BL_FIXED8) || (bl_q == BL_OTF && a[A_BC_BIT]);
    cs_n_d = 1'b1;
    ras_n_d = 1'b1;
    cas_n_d = 1'b1;
    we_n_d = 1'b1;
    cke_d = cke_q;
    ba_d = ba_q;
    addr_d = addr_q;
    sr_d = sr_q;
    pat_d = pat_q;
    dll_off_d = dll_off_q;
    bl_d = bl_q;
    ref_d = 1'b0;
    gap_d = (gap_q == '0) ? gap_q : gap_q - 1'b1;
    if (take && !ok) begin
      ref_d = 1'b1;
    end else if (take) begin
      case (qc.op)
        op_mode: begin
          if (dll_next && qc.ba == BA_MR0) begin
            a[MR0_CL_LSB +: 3] = CL6_CODE;
          end
          if (dll_next && qc.ba == BA_MR2) begin
            a[MR2_CWL_LSB +: 3] = CWL6_CODE;
          end
          {cs_n_d, ras_n_d, cas_n_d, we_n_d} = 4'h0;
          ba_d = qc.ba;
          addr_d = a;
          if (qc.ba == BA_MR0) bl_d = a[MR0_BL_LSB +: 2];
          if (qc.ba == BA_MR1) dll_off_d = a[MR1_DLL_OFF_BIT];
          if (qc.ba == BA_MR3) pat_d = a[MR3_EN_BIT];
          gap_d = GAP_W'(T_MOD_NCK);
        end
        op_read: begin
          a[1:0] = 2'h0;
          if (bl8) a[A_NIB_BIT] = 1'b0;
          cs_n_d = 1'b0;
          cas_n_d = 1'b0;
          ba_d = qc.ba;
          addr_d = a;
          gap_d = GAP_W'(READ_GAP_NCK);
        end
        op_sr_enter: begin
          {cs_n_d, ras_n_d, cas_n_d} = 3'h0;
          cke_d = 1'b0;
          sr_d = 1'b1;
          gap_d = GAP_W'(T_CKSRE_NCK);
        end
        op_sr_exit: begin
          cke_d = 1'b1;
          sr_d = 1'b0;
          gap_d = GAP_W'(T_XS_CYC);
        end
        default: begin
          cs_n_d = 1'b0;
        end
      endcase
    end
    rv_d = link.dq_dev_oe;
    rd_d = link.dq_dev_oe ? link.dq_dev : rd_q;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      gap_q <= '0;
      cke_q <= 1'b1;
      cs_n_q <= 1'b1;
      ras_n_q <= 1'b1;
      cas_n_q <= 1'b1;
      we_n_q <= 1'b1;
      ba_q <= '0;
      addr_q <= '0;
      sr_q <= 1'b0;
      pat_q <= 1'b0;
      dll_off_q <= 1'b0;
      bl_q <= BL_FIXED8;
      ref_q <= 1'b0;
      rv_q <= 1'b0;
      rd_q <= '0;
    end else begin
      gap_q <= gap_d;
      cke_q <= cke_d;
      cs_n_q <= cs_n_d;
      ras_n_q <= ras_n_d;
      cas_n_q <= cas_n_d;
      we_n_q <= we_n_d;
      ba_q <= ba_d;
      addr_q <= addr_d;
      sr_q <= sr_d;
      pat_q <= pat_d;
      dll_off_q <= dll_off_d;
      bl_q <= bl_d;
      ref_q <= ref_d;
      rv_q <= rv_d;
      rd_q <= rd_d;
    end
  end

  assign link.cke = cke_q;
  assign link.cs_n = cs_n_q;
  assign link.ras_n = ras_n_q;
  assign link.cas_n = cas_n_q;
  assign link.we_n = we_n_q;
  assign link.ba = ba_q;
  assign link.addr = addr_q;
  assign link.odt = 1'b0;
  assign link.dq_host = '0;
  assign link.dq_host_oe = 1'b0;
  assign cmd_refused = ref_q;
  assign rd_valid = rv_q;
  assign rd_data = rd_q;
endmodule : dpr_ctrl_host
`default_nettype wire

// File: verif/dpr_link_properties.sv
// Purpose: link-level checks for the pattern-read controller and DRAM pair
// Assumes: mode registers mirrored from the command pins
// Notes: latency, burst shape and lane data tracked from decoded commands
`timescale 1ns/1ns
`default_nettype none
module dpr_link_properties (
  input wire logic clk,
  input wire logic reset,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic odt,
  input wire logic [dpr_pkg::BA_W-1:0] ba,
  input wire logic [dpr_pkg::ADDR_W-1:0] addr,
  input wire logic [dpr_pkg::DQ_W-1:0] dq_dev,
  input wire logic dq_dev_oe,
  input wire logic dqs_dev,
  input wire logic dqs_dev_oe
);
  import dpr_pkg::*;
  logic mode_w, rd_w, nop_w, pat;
  logic [ADDR_W-1:0] mr0_q, mr0_d, mr1_q, mr1_d, mr3_q, mr3_d;
  logic [4:0] cl, al, rl, cnt_q, cnt_d, xs_q, xs_d;
  logic bc_q, bc_d, hi_q, hi_d, cke_q;
  logic [2:0] beat_q, beat_d;
  assign mode_w = !cs_n && !ras_n && !cas_n && !we_n;
  assign rd_w = cke && !cs_n && ras_n && !cas_n && we_n;
  assign nop_w = ras_n && cas_n && we_n;
  assign pat = mr3_q[MR3_EN_BIT];
  assign cl = CL_BASE + {2'h0, mr0_q[MR0_CL_LSB +: 3]};
  always_comb begin
    case (mr1_q[MR1_AL_LSB +: 2])
      AL_CL1: al = cl - 5'h01;
      AL_CL2: al = cl - 5'h02;
      default: al = 5'h00;
    endcase
    rl = al + cl - {4'h0, mr1_q[MR1_DLL_OFF_BIT]};
  end
  always_comb begin
    mr0_d = (mode_w && ba[1:0] == 2'h0) ? addr : mr0_q;
    mr1_d = (mode_w && ba[1:0] == 2'h1) ? addr : mr1_q;
    mr3_d = (mode_w && ba[1:0] == 2'h3) ? addr : mr3_q;
    cnt_d = (cnt_q != 5'h00 && cnt_q != 5'h1f) ? cnt_q + 5'h01 : cnt_q;
    bc_d = bc_q;
    hi_d = hi_q;
    if (rd_w) begin
      cnt_d = 5'h01;
      bc_d = mr0_q[1:0] == BL_FIXED4 ||
             (mr0_q[1:0] == BL_OTF && !addr[A_BC_BIT]);
      hi_d = addr[A_NIB_BIT];
    end
    beat_d = dq_dev_oe ? beat_q + 3'h1 :
             ((bc_q && hi_q) ? NIB_HI_START : NIB_LO_START);
    xs_d = (cke && !cke_q) ? 5'h01 :
           ((xs_q != 5'h00 && xs_q != 5'h1f) ? xs_q + 5'h01 : xs_q);
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      mr0_q <= MR_RST;
      mr1_q <= MR_RST;
      mr3_q <= MR_RST;
      cnt_q <= 5'h00;
      bc_q <= 1'b0;
      hi_q <= 1'b0;
      beat_q <= NIB_LO_START;
      xs_q <= 5'h00;
      cke_q <= 1'b1;
    end else begin
      mr0_q <= mr0_d;
      mr1_q <= mr1_d;
      mr3_q <= mr3_d;
      cnt_q <= cnt_d;
      bc_q <= bc_d;
      hi_q <= hi_d;
      beat_q <= beat_d;
      xs_q <= xs_d;
      cke_q <= cke;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  chk_read_latency_count: assert property (
    $rose(dq_dev_oe) |-> cnt_q == rl) else $error("read latency wrong");
  chk_burst_eight_beats: assert property (
    $rose(dq_dev_oe) && !bc_q |-> dq_dev_oe[*8] ##1 !dq_dev_oe)
    else $error("eight-beat burst length wrong");
  chk_burst_chop_four: assert property (
    $rose(dq_dev_oe) && bc_q |-> dq_dev_oe[*4] ##1 !dq_dev_oe)
    else $error("chopped burst length wrong");
  chk_pattern_beat_data: assert property (
    dq_dev_oe && pat && mr3_q[1:0] == LOC_CAL
    |-> dq_dev == {DQ_W{CAL_PATTERN[beat_q]}})
    else $error("pattern beat data wrong");
  chk_reserved_loc_zero: assert property (
    dq_dev_oe && pat && mr3_q[1:0] != LOC_CAL |-> dq_dev == 16'h0000)
    else $error("reserved location not zero");
  chk_lanes_match: assert property (
    dq_dev_oe && pat |-> dq_dev[15:8] == dq_dev[7:0])
    else $error("byte lanes differ");
  chk_read_low_bits: assert property (
    rd_w |-> addr[1:0] == 2'h0) else $error("read low address bits set");
  chk_bl8_nibble_low: assert property (
    rd_w && mr0_q[1:0] == BL_FIXED8 |-> !addr[A_NIB_BIT])
    else $error("eight-beat read with A2 high");
  chk_dll_off_cl6: assert property (
    mode_w && ba[1:0] == 2'h0 && mr1_q[MR1_DLL_OFF_BIT]
    |-> addr[MR0_CL_LSB +: 3] == CL6_CODE) else $error("CL not six");
  chk_dll_off_cwl6: assert property (
    mode_w && ba[1:0] == 2'h2 && mr1_q[MR1_DLL_OFF_BIT]
    |-> addr[MR2_CWL_LSB +: 3] == CWL6_CODE) else $error("CWL not six");
  chk_strobe_even_beats: assert property (
    dqs_dev_oe == dq_dev_oe && (!dq_dev_oe || dqs_dev == !beat_q[0]))
    else $error("read strobe phase wrong");
  chk_pattern_only_reads: assert property (
    !cs_n && pat |-> nop_w || rd_w || (mode_w && ba[1:0] == 2'h3))
    else $error("command other than read while pattern on");
  chk_no_pat_dll_off: assert property (
    rd_w && pat |-> !mr1_q[MR1_DLL_OFF_BIT])
    else $error("pattern read with DLL off");
  chk_mode_after_xs: assert property (
    mode_w |-> xs_q == 5'h00 || xs_q >= T_XS_CYC)
    else $error("mode write before exit wait");
  chk_odt_low: assert property (!odt) else $error("odt high");
  cov_chop_high: cover property ($rose(dq_dev_oe) && bc_q && hi_q);
  cov_dll_off_read: cover property (rd_w && mr1_q[MR1_DLL_OFF_BIT]);
  cov_sr_exit: cover property (cke && !cke_q);
endmodule : dpr_link_properties
`default_nettype wire

// File: verif/testbench.sv
// Purpose: drives the controller end and checks read data from the DRAM end
// Assumes: inputs change on the falling clock edge
// Notes: array_data held constant; ordinary reads return it every beat
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import dpr_pkg::*;
  localparam logic [13:0] BASE = 14'h2ff8;
  localparam logic [15:0] ARR = 16'h5a3c;
  logic clk, reset, cmd_valid, cmd_ready, cmd_refused, rd_valid;
  logic dll_off, pattern_en, in_self_refresh, read_busy;
  logic [15:0] rd_data;
  dpr_cmd_s cmd;
  logic [15:0] q[$];
  int n_mismatch, compares, n_ref;
  dpr_link_if link (.clk(clk));
  dpr_ctrl_host dpr_ctrl_host_i (.clk(clk), .reset(reset), .link(link),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd),
    .cmd_refused(cmd_refused), .rd_valid(rd_valid), .rd_data(rd_data));
  dpr_dram_dev dpr_dram_dev_i (.clk(clk), .reset(reset), .link(link),
    .array_data(ARR), .dll_off(dll_off), .pattern_en(pattern_en),
    .in_self_refresh(in_self_refresh), .read_busy(read_busy));
  dpr_link_properties dpr_link_properties_i (.clk(clk), .reset(reset),
    .cke(link.cke), .cs_n(link.cs_n), .ras_n(link.ras_n),
    .cas_n(link.cas_n), .we_n(link.we_n), .odt(link.odt), .ba(link.ba),
    .addr(link.addr), .dq_dev(link.dq_dev), .dq_dev_oe(link.dq_dev_oe),
    .dqs_dev(link.dqs_dev), .dqs_dev_oe(link.dqs_dev_oe));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (rd_valid === 1'b1) q.push_back(rd_data);
    if (cmd_refused === 1'b1) n_ref++;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic issue(input dpr_op_e op, input logic [2:0] b,
                       input logic [13:0] a);
    @(negedge clk);
    cmd <= '{op, b, a};
    cmd_valid <= 1'b1;
    for (int i = 0; i < 200; i++) begin
      #1;
      if (cmd_ready === 1'b1) break;
      @(negedge clk);
    end
    if (cmd_ready !== 1'b1) n_mismatch++;
    @(posedge clk);
    @(negedge clk);
    cmd_valid <= 1'b0;
  endtask : issue
  task automatic refuse(input dpr_op_e op, input logic [2:0] b,
                        input logic [13:0] a);
    int r0;
    r0 = n_ref;
    issue(op, b, a);
    repeat (60) @(posedge clk);
    check(16'(n_ref - r0), 16'h0001);
  endtask : refuse
  task automatic setup(input logic [1:0] bl, input logic [1:0] loc);
    issue(op_mode, BA_MR3, 14'h0000);
    issue(op_mode, BA_MR0, 14'h0020 | {12'h000, bl});
    issue(op_mode, BA_MR3, 14'h0004 | {12'h000, loc});
  endtask : setup
  task automatic rd_check(input logic [1:0] bl, input logic [13:0] a,
                          input int kind);
    int n;
    int st;
    logic [15:0] exp;
    n = (bl == BL_FIXED4 || (bl == BL_OTF && !a[A_BC_BIT])) ? 4 : 8;
    st = (n == 4 && a[A_NIB_BIT]) ? 4 : 0;
    q.delete();
    issue(op_read, 3'h5, a);
    for (int i = 0; i < 150 && q.size() < n; i++) @(posedge clk);
    repeat (12) @(posedge clk);
    check(16'(q.size()), 16'(n));
    for (int k = 0; k < q.size() && k < n; k++) begin
      case (kind)
        0: exp = {16{CAL_PATTERN[st+k]}};
        1: exp = 16'h0000;
        default: exp = ARR;
      endcase
      check(q[k], exp);
    end
  endtask : rd_check
  task automatic conclude();
    $display("Mismatches %0d, compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : conclude
  initial begin
    repeat (30000) @(posedge clk);
    n_mismatch++;
    conclude();
  end
  initial begin
    n_mismatch = 0;
    compares = 0;
    n_ref = 0;
    reset = 1'b1;
    cmd_valid = 1'b0;
    cmd = '0;
    repeat (20) @(posedge clk);
    @(negedge clk);
    reset <= 1'b0;
    @(negedge clk);
    check({12'h000, dll_off, pattern_en, in_self_refresh, read_busy},
          16'h0000);
    issue(op_nop, 3'h7, 14'h3fff);
    refuse(op_sr_exit, 3'h0, 14'h0000);
    check({12'h000, dll_off, pattern_en, in_self_refresh, read_busy},
          16'h0000);
    for (int b = 0; b < 3; b++) begin
      setup(2'(b), LOC_CAL);
      rd_check(2'(b), BASE | 14'h0004, 0);
      rd_check(2'(b), BASE | 14'h1000, 0);
    end
    check({15'h0000, pattern_en}, 16'h0001);
    refuse(op_mode, BA_MR0, 14'h0020);
    refuse(op_sr_enter, 3'h0, 14'h0000);
    rd_check(BL_FIXED4, BASE, 0);
    for (int l = 1; l < 4; l++) begin
      setup(BL_FIXED8, 2'(l));
      rd_check(BL_FIXED8, BASE, 1);
    end
    issue(op_mode, BA_MR3, 14'h0000);
    issue(op_mode, BA_MR1, 14'h0001);
    issue(op_sr_enter, 3'h0, 14'h0000);
    repeat (30) @(posedge clk);
    check({15'h0000, in_self_refresh}, 16'h0001);
    check({15'h0000, dll_off}, 16'h0001);
    refuse(op_mode, BA_MR0, 14'h0020);
    issue(op_sr_exit, 3'h0, 14'h0000);
    repeat (30) @(posedge clk);
    check({15'h0000, in_self_refresh}, 16'h0000);
    issue(op_mode, BA_MR2, 14'h0000);
    issue(op_mode, BA_MR0, 14'h0000);
    rd_check(BL_FIXED8, BASE, 2);
    issue(op_mode, BA_MR3, 14'h0004);
    refuse(op_read, 3'h0, BASE);
    issue(op_mode, BA_MR3, 14'h0000);
    issue(op_mode, BA_MR1, 14'h0008);
    rd_check(BL_FIXED8, BASE, 2);
    check({15'h0000, dll_off}, 16'h0000);
    issue(op_mode, BA_MR1, 14'h0010);
    rd_check(BL_FIXED8, BASE, 2);
    conclude();
  end
endmodule : testbench
`default_nettype wire
